/* design/lpms_sequencer.sv */
/*
  Low-power mode sequencer: active, sleep, wait and backup, with wake-up handling.
  Assumes the core pulses wfe/wfi and the controls are stable while it sleeps.
*/
`timescale 1ns/1ps
module lpms_sequencer (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         wfe_exec,
  input  wire logic                         wfi_exec,
  input  wire logic                         deep_sleep_select,
  input  wire logic                         low_power_select,
  input  wire logic                         fast_rc_osc_enable,
  input  wire logic                         force_wakeup_pin_n,
  input  wire logic [lpms_pkg::DEB_W-1:0]   force_wakeup_pin_debounce,
  input  wire logic [lpms_pkg::NWAKE-1:0]   wakeup_inputs,
  input  wire logic [lpms_pkg::NWAKE-1:0]   wakeup_input_enables,
  input  wire logic [lpms_pkg::NWAKE-1:0]   fast_startup_enables,
  input  wire logic [lpms_pkg::DEB_W-1:0]   wakeup_debounce,
  input  wire logic                         supply_monitor_alarm,
  input  wire logic                         supply_monitor_wake_en,
  input  wire logic                         rtc_alarm,
  input  wire logic                         rtc_wake_en,
  input  wire logic                         real_time_timer_alarm,
  input  wire logic                         rtt_wake_en,
  input  wire logic                         usb_wakeup,
  input  wire logic                         irq_pending,
  input  wire logic                         event_pending,
  output logic                              core_clk_en,
  output logic                              periph_clk_en,
  output logic                              mem_clk_en,
  output logic                              core_power_en,
  output logic                              regulator_en,
  output logic                              core_reset,
  output logic                              fast_startup,
  output logic [2:0]                        rc_freq_sel,
  output logic                              main_clk_is_rc,
  output logic [2:0]                        mode
);
  // Wide enough for the regulator start count
  localparam int unsigned CNT_W         = 16;
  // Loose bound on the fast restart, far inside the ten microsecond budget
  localparam int          RESTART_BOUND = 2 * lpms_pkg::RESYNC_CYCLES;

  lpms_pkg::lpms_state_t      state_q;
  lpms_pkg::lpms_state_t      state_d;
  logic [CNT_W-1:0]           cnt_q;
  logic [CNT_W-1:0]           cnt_d;
  logic                       wfi_entry_q;
  logic                       wfi_entry_d;
  logic                       core_clk_en_d;
  logic                       periph_clk_en_d;
  logic                       mem_clk_en_d;
  logic                       core_power_en_d;
  logic                       regulator_en_d;
  logic                       core_reset_d;
  logic                       fast_startup_d;
  logic [2:0]                 rc_freq_sel_d;
  logic                       main_clk_is_rc_d;
  logic [2:0]                 mode_d;
  logic                       force_wakeup_pin_level;
  logic [lpms_pkg::NWAKE-1:0] wk_level;
  logic [lpms_pkg::NWAKE-1:0] wk_change;
  logic                       alarm_wake;
  logic                       backup_wake;
  logic                       fast_event;
  logic                       sleep_wake;

  // Force-wakeup pin filter; a settled low level is the wake request
  lpms_deb_if force_wakeup_pin_if ();

  assign force_wakeup_pin_if.sample_in = force_wakeup_pin_n;
  assign force_wakeup_pin_if.period    = force_wakeup_pin_debounce;
  assign force_wakeup_pin_level        = force_wakeup_pin_if.stable_out;

  lpms_debounce i_force_wakeup_pin_deb (
    .clk (clk),
    .rst (rst),
    .dif (force_wakeup_pin_if)
  );

  // One filter per wake-up input
  for (genvar g = 0; g < lpms_pkg::NWAKE; g++) begin : g_wake
    lpms_deb_if wk_if ();

    assign wk_if.sample_in = wakeup_inputs[g];
    assign wk_if.period    = wakeup_debounce;
    assign wk_level[g]     = wk_if.stable_out;
    assign wk_change[g]    = wk_if.changed;

    lpms_debounce i_wk_deb (
      .clk (clk),
      .rst (rst),
      .dif (wk_if)
    );
  end

  assign alarm_wake  = (rtc_alarm & rtc_wake_en) | (real_time_timer_alarm & rtt_wake_en);
  // Backup wakes on any enabled source
  assign backup_wake = ~force_wakeup_pin_level
                     | (|(wk_change & wakeup_input_enables))
                     | (supply_monitor_alarm & supply_monitor_wake_en)
                     | alarm_wake;
  // Fast startup inputs react to a low level, not an edge
  assign fast_event  = (|(~wk_level & fast_startup_enables)) | alarm_wake | usb_wakeup;
  // An event-entered sleep also ends on fast startup sources
  assign sleep_wake  = wfi_entry_q ? irq_pending : (event_pending | fast_event);

  always_comb begin
    state_d     = state_q;
    cnt_d       = '0;
    wfi_entry_d = wfi_entry_q;
    case (state_q)
      lpms_pkg::LPMS_ACTIVE: begin
        if (wfe_exec && deep_sleep_select) begin
          state_d = lpms_pkg::LPMS_BACKUP;
        end else if (wfe_exec && low_power_select) begin
          state_d = lpms_pkg::LPMS_WAIT_SYNC;
        end else if (wfe_exec || wfi_exec) begin
          state_d     = lpms_pkg::LPMS_SLEEP;
          wfi_entry_d = ~wfe_exec;
        end
      end
      lpms_pkg::LPMS_SLEEP: begin
        if (sleep_wake) begin
          state_d = lpms_pkg::LPMS_ACTIVE;
        end
      end
      lpms_pkg::LPMS_WAIT_SYNC: begin
        // Clocks keep running until the resync cycles are spent
        if (cnt_q == CNT_W'(lpms_pkg::RESYNC_CYCLES - 1)) begin
          state_d = lpms_pkg::LPMS_WAIT;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      lpms_pkg::LPMS_WAIT: begin
        if (fast_event) begin
          state_d = lpms_pkg::LPMS_RESTART;
        end
      end
      lpms_pkg::LPMS_BACKUP: begin
        if (backup_wake) begin
          state_d = lpms_pkg::LPMS_POWERUP;
        end
      end
      lpms_pkg::LPMS_POWERUP: begin
        // Core stays in reset for the whole regulator start time
        if (cnt_q == CNT_W'(lpms_pkg::REG_START_CYC)) begin
          state_d = lpms_pkg::LPMS_ACTIVE;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      lpms_pkg::LPMS_RESTART: begin
        if (cnt_q == CNT_W'(lpms_pkg::RESYNC_CYCLES - 1)) begin
          state_d = lpms_pkg::LPMS_ACTIVE;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = lpms_pkg::LPMS_ACTIVE;
      end
    endcase

    // Outputs decode the next state so they switch with it, not a cycle late
    core_clk_en_d    = 1'b1;
    periph_clk_en_d  = 1'b1;
    mem_clk_en_d     = 1'b1;
    core_power_en_d  = 1'b1;
    regulator_en_d   = 1'b1;
    core_reset_d     = 1'b0;
    fast_startup_d   = 1'b0;
    rc_freq_sel_d    = lpms_pkg::RC_FREQ_4MHZ;
    main_clk_is_rc_d = fast_rc_osc_enable;
    mode_d           = state_d;
    case (state_d)
      lpms_pkg::LPMS_SLEEP: begin
        core_clk_en_d = 1'b0;
      end
      lpms_pkg::LPMS_WAIT: begin
        core_clk_en_d   = 1'b0;
        periph_clk_en_d = 1'b0;
        mem_clk_en_d    = 1'b0;
      end
      lpms_pkg::LPMS_BACKUP: begin
        core_clk_en_d   = 1'b0;
        periph_clk_en_d = 1'b0;
        mem_clk_en_d    = 1'b0;
        core_power_en_d = 1'b0;
        regulator_en_d  = 1'b0;
      end
      lpms_pkg::LPMS_POWERUP: begin
        core_clk_en_d   = 1'b0;
        periph_clk_en_d = 1'b0;
        mem_clk_en_d    = 1'b0;
        core_power_en_d = 1'b0;
        core_reset_d    = 1'b1;
      end
      lpms_pkg::LPMS_RESTART: begin
        // Clock tree is rebuilt on the fast RC before the core runs again
        core_clk_en_d    = 1'b0;
        periph_clk_en_d  = 1'b0;
        mem_clk_en_d     = 1'b0;
        fast_startup_d   = 1'b1;
        main_clk_is_rc_d = 1'b1;
      end
      default: begin
        core_clk_en_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q        <= lpms_pkg::LPMS_ACTIVE;
      cnt_q          <= '0;
      wfi_entry_q    <= 1'b0;
      core_clk_en    <= 1'b1;
      periph_clk_en  <= 1'b1;
      mem_clk_en     <= 1'b1;
      core_power_en  <= 1'b1;
      regulator_en   <= 1'b1;
      core_reset     <= 1'b0;
      fast_startup   <= 1'b0;
      rc_freq_sel    <= lpms_pkg::RC_FREQ_4MHZ;
      main_clk_is_rc <= 1'b1;
      mode           <= lpms_pkg::LPMS_ACTIVE;
    end else begin
      state_q        <= state_d;
      cnt_q          <= cnt_d;
      wfi_entry_q    <= wfi_entry_d;
      core_clk_en    <= core_clk_en_d;
      periph_clk_en  <= periph_clk_en_d;
      mem_clk_en     <= mem_clk_en_d;
      core_power_en  <= core_power_en_d;
      regulator_en   <= regulator_en_d;
      core_reset     <= core_reset_d;
      fast_startup   <= fast_startup_d;
      rc_freq_sel    <= rc_freq_sel_d;
      main_clk_is_rc <= main_clk_is_rc_d;
      mode           <= mode_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  backup_power_off_a: assert property (
    state_q == lpms_pkg::LPMS_BACKUP |-> !core_power_en && !regulator_en)
    else $error("core supply on in backup");
  wait_clocks_off_a: assert property (
    state_q == lpms_pkg::LPMS_WAIT |->
      !core_clk_en && !periph_clk_en && !mem_clk_en && core_power_en)
    else $error("wait clocks or power wrong");
  sleep_core_only_a: assert property (
    state_q == lpms_pkg::LPMS_SLEEP |-> !core_clk_en && periph_clk_en && mem_clk_en)
    else $error("sleep clocks wrong");
  deep_beats_lpm_a: assert property (
    state_q == lpms_pkg::LPMS_ACTIVE && wfe_exec && deep_sleep_select
      |=> state_q == lpms_pkg::LPMS_BACKUP)
    else $error("event wait with deep select missed backup");
  wait_entry_a: assert property (
    state_q == lpms_pkg::LPMS_ACTIVE && wfe_exec && !deep_sleep_select && low_power_select
      |=> state_q == lpms_pkg::LPMS_WAIT_SYNC)
    else $error("event wait with select missed wait");
  sleep_entry_a: assert property (
    state_q == lpms_pkg::LPMS_ACTIVE && wfi_exec && !wfe_exec
      |=> state_q == lpms_pkg::LPMS_SLEEP)
    else $error("interrupt wait missed sleep");
  backup_wake_a: assert property (
    state_q == lpms_pkg::LPMS_BACKUP && backup_wake |=> state_q == lpms_pkg::LPMS_POWERUP)
    else $error("backup wake ignored");
  powerup_reset_a: assert property (
    state_q == lpms_pkg::LPMS_POWERUP |-> core_reset && regulator_en && !core_clk_en)
    else $error("power-up without core reset");
  fast_start_a: assert property (
    state_q == lpms_pkg::LPMS_RESTART |->
      fast_startup && main_clk_is_rc && rc_freq_sel == lpms_pkg::RC_FREQ_4MHZ)
    else $error("fast startup clock setup wrong");
  restart_bound_a: assert property (
    state_q == lpms_pkg::LPMS_RESTART |-> ##[1:RESTART_BOUND] state_q == lpms_pkg::LPMS_ACTIVE)
    else $error("wait restart too slow");

  sleep_seen_c: cover property (state_q == lpms_pkg::LPMS_SLEEP);
  wait_wake_c: cover property (state_q == lpms_pkg::LPMS_WAIT && fast_event);
  backup_wake_c: cover property (state_q == lpms_pkg::LPMS_BACKUP && backup_wake);
  powerup_done_c: cover property (
    state_q == lpms_pkg::LPMS_POWERUP ##1 state_q == lpms_pkg::LPMS_ACTIVE);
endmodule

/* design/lpms_pkg.sv */
/*
  Constants, states and timing for the low-power mode sequencer.
  Assumes a single 125 MHz clock and synchronous inputs.
*/
// Operation
// - Backup removes regulator and core supply
// - Debounced low force-wakeup pin leaves backup
// - Debounced enabled wake-up input transition leaves backup
// - Enabled monitor, RTC or timer alarm leaves backup
// - Wait stops core, peripheral, memory clocks; power kept
// - Wait-for-event with low-power select enters wait
// - Fast-startup input, alarms or USB exit wait
// - Wait entry delayed by resync after RC enable
// - Wait restart finishes within ten microseconds
// - Sleep stops only core clock
// - Interrupt wait, or event wait without select, sleeps
// - Sleep wakes by interrupt or event per entry
// - Regulator output grounded; normal within 400 us
// - Backup wake re-enables core supply, then reset; code holds core_power_en off during the reset and raises it as reset ends
// - Fast startup restarts RC at 4 MHz, core clock
package lpms_pkg;
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned WAIT_RESTART_NS = 10000;
  localparam int unsigned REG_START_NS    = 400000;
  localparam int unsigned RESYNC_CYCLES   = 4;
  localparam int unsigned WAIT_RESTART_CYC = (WAIT_RESTART_NS * CLK_MHZ) / 1000 - 1;
  localparam int unsigned REG_START_CYC  = (REG_START_NS * CLK_MHZ) / 1000 - 1;
  localparam int unsigned DEB_W          = 8;
  localparam int unsigned NWAKE          = 16;
  localparam logic [2:0]  RC_FREQ_4MHZ   = 3'h0;

  typedef enum logic [2:0] {
    LPMS_ACTIVE   = 3'b000,
    LPMS_SLEEP    = 3'b001,
    LPMS_WAIT_SYNC = 3'b010,
    LPMS_WAIT     = 3'b011,
    LPMS_BACKUP   = 3'b100,
    LPMS_POWERUP  = 3'b101,
    LPMS_RESTART  = 3'b110
  } lpms_state_t;
endpackage

/* design/lpms_deb_if.sv */
/*
  Carrier between the sequencer and its debounce filter.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface lpms_deb_if;
  logic                           sample_in;
  logic [lpms_pkg::DEB_W-1:0]     period;
  logic                           stable_out;
  logic                           changed;
  modport filt (input sample_in, input period, output stable_out, output changed);
  modport user (output sample_in, output period, input stable_out, input changed);
endinterface

/* design/lpms_debounce.sv */
/*
  Debounce filter: the output follows the input once it held steady for period+1 cycles.
  Assumes a synchronous input; resets to high (idle, not asserted).
*/
`timescale 1ns/1ps
module lpms_debounce (
  input  wire logic clk,
  input  wire logic rst,
  lpms_deb_if.filt  dif
);
  logic [lpms_pkg::DEB_W-1:0] cnt_q, cnt_d;
  logic                       out_q, out_d;
  logic                       chg_q, chg_d;

  always_comb begin
    cnt_d = '0;
    out_d = out_q;
    chg_d = 1'b0;
    if (dif.sample_in != out_q) begin
      if (cnt_q >= dif.period) begin
        out_d = dif.sample_in;
        chg_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      out_q <= 1'b1;
      chg_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
      chg_q <= chg_d;
    end
  end

  assign dif.stable_out = out_q;
  assign dif.changed    = chg_q;
endmodule

/* dv/lpms_core_model.sv */
/* Core model: turns a request into a one-cycle wait instruction pulse.
   Assumes the bench sets the mode selects before the request. */
`timescale 1ns/1ps
module lpms_core_model (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic use_wfi,
  output logic      wfe_exec = 1'b0,
  output logic      wfi_exec = 1'b0
);
  // Selects are stable before the pulse leaves
  always @(posedge clk) begin
    wfe_exec <= go & ~use_wfi;
    wfi_exec <= go & use_wfi;
  end
endmodule

/* dv/low_power_mode_sequencer_bench.sv */
/* Bench for the low-power mode sequencer: one row per entry path (sleep twice, wait, backup), then wake tests.
   Assumes the core model pulses the wait instructions. */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR %0t outputs differ", $time); end end
module low_power_mode_sequencer_bench;
  logic clk = 0, rst = 1, go = 0, use_wfi = 0, wfe_exec, wfi_exec, usb_wakeup = 0;
  logic deep_sleep_select = 0, low_power_select = 0, fast_rc_osc_enable = 1;
  logic force_wakeup_pin_n = 1, irq_pending = 0, event_pending = 0, rtc_alarm = 0;
  logic supply_monitor_alarm = 0, supply_monitor_wake_en = 1, rtc_wake_en = 1;
  logic real_time_timer_alarm = 0, rtt_wake_en = 1;
  logic [7:0] force_wakeup_pin_debounce = 8'h02, wakeup_debounce = 8'h02;
  logic [15:0] wakeup_inputs = 16'hffff, wakeup_input_enables = 16'h0001;
  logic [15:0] fast_startup_enables = 16'h0001;
  logic core_clk_en, periph_clk_en, mem_clk_en, core_power_en, regulator_en;
  logic core_reset, fast_startup, main_clk_is_rc;
  logic [2:0] rc_freq_sel, mode;
  // Selects and instruction, then core, peripheral, memory clocks, power, regulator, mode
  logic [10:0] rows [4] = '{11'h179, 11'h079, 11'h21b, 11'h604};
  int err_total = 0, num_checks = 0, w;
  lpms_sequencer i_dut (.*);
  lpms_core_model i_core (.*);
  initial forever #4 clk = ~clk;
  task automatic print_verdict;
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic enter(input logic [2:0] sel);
    {deep_sleep_select, low_power_select, use_wfi} = sel;
    @(posedge clk) #1 go = 1;
    @(posedge clk) #1 go = 0;
    repeat (20) @(posedge clk);
    #1;
  endtask
  initial begin
    #700000 err_total++;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 0;
    `CHK({core_clk_en, core_power_en}, 2'h3)
    foreach (rows[i]) begin
      enter(rows[i][10:8]);
      `CHK({core_clk_en, periph_clk_en, mem_clk_en, core_power_en, regulator_en, mode}, rows[i][7:0])
      {irq_pending, event_pending, rtc_alarm, force_wakeup_pin_n} = 4'he;
      for (w = 0; w < 60000 && !(core_clk_en === 1'b1 && core_power_en === 1'b1); w++)
        @(posedge clk) #1;
      `CHK(core_clk_en, 1'b1)
      `CHK(core_reset, 1'b0)
      `CHK(fast_startup, 1'b0)
      `CHK(i != 2 || (main_clk_is_rc === 1'b1 && rc_freq_sel === lpms_pkg::RC_FREQ_4MHZ), 1'b1)
      `CHK(i != 2 || w < 1250, 1'b1)
      {irq_pending, event_pending, rtc_alarm, force_wakeup_pin_n} = 4'h1;
      rst = 1;
      @(posedge clk) #1 rst = 0;
    end
    // A disabled wake-up input must not end backup; the enabled one must
    enter(3'h4);
    wakeup_inputs = 16'hfffd;
    repeat (30) @(posedge clk);
    #1;
    `CHK(regulator_en, 1'b0)
    wakeup_inputs = 16'hfffc;
    for (w = 0; w < 200 && regulator_en !== 1'b1; w++) @(posedge clk) #1;
    `CHK(regulator_en, 1'b1)
    print_verdict;
  end
endmodule
